// *** rtl/meta_bundle_pkg.sv ***
/*
 * Constants for the received audio metadata bundle: bundle layout,
 * raw packet field positions and the small control register map.
 * Assumes the depacketizer hands over header bytes 1..2 and body bytes 0..19.
 */
package meta_bundle_pkg;
   localparam int HDR_W    = 16;
   localparam int BODY_W   = 160;
   localparam int BUNDLE_W = 165;
   localparam int SUB_N    = 4;
   localparam int DSC_W    = 40;
   localparam int SUB_BASE = 5;
   // Bundle fields, common and spatial layout
   localparam int SEL_BIT  = 0;
   localparam int VIEWS_LO = 1;
   localparam int VIEWS_W  = 2;
   localparam int STR_LO   = 3;
   localparam int STR_W    = 2;
   localparam int CC_LO    = 5;
   localparam int CC_W     = 5;
   localparam int GAPA_LO  = 10;
   localparam int GAPA_W   = 3;
   localparam int CHANNEL_ALLOC_STANDARD_LO  = 13;
   localparam int CHANNEL_ALLOC_STANDARD_W   = 4;
   localparam int GAPB_LO  = 17;
   localparam int GAPB_W   = 4;
   localparam int SPK_LO   = 21;
   localparam int SPK_W    = 8;
   localparam int GAPC_LO  = 29;
   localparam int GAPC_W   = 136;
   // Raw packet positions
   localparam int RAW_SEL_BIT  = 0;
   localparam int RAW_VIEWS_LO = 8;
   localparam int RAW_STR_LO   = 10;
   localparam int RAW_CC_LO    = 0;
   localparam int RAW_CHANNEL_ALLOC_STANDARD_LO  = 16;
   localparam int RAW_SPK_LO   = 24;
   // Descriptor offsets, same in raw body and in bundle
   localparam int DSC_LEFT   = 0;
   localparam int DSC_RIGHT  = 1;
   localparam int DSC_GA_LO  = 2;
   localparam int DSC_GA_W   = 6;
   localparam int DSC_TYPE   = 8;
   localparam int TYPE_W     = 3;
   localparam int DSC_MIXED  = 11;
   localparam int DSC_SVALID = 12;
   localparam int DSC_GB_LO  = 13;
   localparam int DSC_GB_W   = 2;
   localparam int DSC_LCV    = 15;
   localparam int DSC_LANG   = 16;
   localparam int LANG_W     = 24;
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
   localparam int CTRL_EN_BIT  = 0;
   localparam logic CTRL_EN_RST = 1'h1;
   localparam int STAT_VALID   = 0;
   localparam int STAT_LAYOUT  = 1;
   localparam int STAT_CNT_LO  = 8;
   localparam int CNT_W        = 8;
endpackage : meta_bundle_pkg

// *** rtl/meta_fmt_if.sv ***
/*
 * Carrier between the bundle top and its field formatter.
 * Assumes meta_bundle_pkg is compiled first.
 */
`timescale 1ns/1ps
interface meta_fmt_if;
   import meta_bundle_pkg::*;
   logic [HDR_W-1:0]    hdr;
   logic [BODY_W-1:0]   body;
   logic [BUNDLE_W-1:0] bundle;
   modport ctl (output hdr, output body, input bundle);
   modport fmt (input hdr, input body, output bundle);
endinterface : meta_fmt_if

// *** rtl/meta_field_map.sv ***
/*
 * Combinational map from a raw metadata packet to bundle layout.
 * Assumes the caller registers the result; no state is kept here.
 */
`timescale 1ns/1ps
module meta_field_map
(
   meta_fmt_if.fmt f
);
   import meta_bundle_pkg::*;

   logic [DSC_W-1:0] desc [SUB_N];

   ////////////////////////////////////////////////////////////////////
   // One descriptor per subpacket, reserved gaps forced low
   genvar k;
   generate
      for (k = 0; k < SUB_N; k++)
      begin : g_desc
         localparam int RB = k * DSC_W;
         assign desc[k] = {f.body[RB+DSC_LANG +: LANG_W],
                           f.body[RB+DSC_LCV],
                           {DSC_GB_W{1'b0}},
                           f.body[RB+DSC_SVALID],
                           f.body[RB+DSC_MIXED],
                           f.body[RB+DSC_TYPE +: TYPE_W],
                           {DSC_GA_W{1'b0}},
                           f.body[RB+DSC_RIGHT],
                           f.body[RB+DSC_LEFT]};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      f.bundle = '0;
      f.bundle[SEL_BIT] = f.hdr[RAW_SEL_BIT];
      f.bundle[VIEWS_LO +: VIEWS_W] = f.hdr[RAW_VIEWS_LO +: VIEWS_W];
      f.bundle[STR_LO +: STR_W] = f.hdr[RAW_STR_LO +: STR_W];
      if (f.hdr[RAW_SEL_BIT])
      begin
         f.bundle[CC_LO +: CC_W] = f.body[RAW_CC_LO +: CC_W];
         f.bundle[CHANNEL_ALLOC_STANDARD_LO +: CHANNEL_ALLOC_STANDARD_W] = f.body[RAW_CHANNEL_ALLOC_STANDARD_LO +: CHANNEL_ALLOC_STANDARD_W];
         f.bundle[SPK_LO +: SPK_W] = f.body[RAW_SPK_LO +: SPK_W];
      end
      else
      begin
         for (int i = 0; i < SUB_N; i++)
         begin
            f.bundle[SUB_BASE + i*DSC_W +: DSC_W] = desc[i];
         end
      end
   end
endmodule : meta_field_map

// *** rtl/sink_audio_metadata_bundle.sv ***
/*
 * Receive-side audio metadata bundle: captures each good metadata packet
 * from the depacketizer and presents it as a wide field bundle, with a
 * small control/status register port.
 * Assumes packet inputs are synchronous to mclk_i and that pkt_valid_i
 * pulses once per packet with header and body valid beside it.
 */
`timescale 1ns/1ps
module sink_audio_metadata_bundle
(
   input  wire logic                                 mclk_i,
   input  wire logic                                 arst_n_i,
   input  wire logic                                 pkt_valid_i,
   input  wire logic                                 pkt_ok_i,
   input  wire logic [meta_bundle_pkg::HDR_W-1:0]    pkt_hdr_i,
   input  wire logic [meta_bundle_pkg::BODY_W-1:0]   pkt_body_i,
   input  wire logic [meta_bundle_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [meta_bundle_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                                 reg_wr_i,
   input  wire logic                                 reg_rd_i,
   output logic      [meta_bundle_pkg::DATA_W-1:0]   reg_rdata_o,
   output logic      [meta_bundle_pkg::BUNDLE_W-1:0] audio_metadata_bundle_o,
   output logic                                      bundle_update_o
);
   import meta_bundle_pkg::*;

   logic [1:0]          rst_sync;
   logic                rst_n;
   logic                capture_en;
   logic                have_pkt;
   logic [CNT_W-1:0]    pkt_count;
   logic                cap;
   logic [DATA_W-1:0]   next_rdata;
   logic [HDR_W-1:0]    hdr_q;
   logic [BODY_W-1:0]   body_q;

   meta_fmt_if fmt_bus ();

   ////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   assign rst_n = rst_sync[1];

   ////////////////////////////////////////////////////////////////////
   // Field formatting
   assign fmt_bus.hdr  = pkt_hdr_i;
   assign fmt_bus.body = pkt_body_i;

   meta_field_map u_map
   (
      .f (fmt_bus.fmt)
   );

   // Packets with a bad check are dropped so a corrupt one never
   // overwrites a good bundle.
   assign cap = pkt_valid_i && pkt_ok_i && capture_en;

   ////////////////////////////////////////////////////////////////////
   // Bundle capture
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         audio_metadata_bundle_o <= '0;
      else if (cap)
         audio_metadata_bundle_o <= fmt_bus.bundle;
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         bundle_update_o <= 1'b0;
      else
         bundle_update_o <= cap;
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         have_pkt <= 1'b0;
      else if (cap)
         have_pkt <= 1'b1;
   end

   // Wraps; software takes differences between reads
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         pkt_count <= '0;
      else if (cap)
         pkt_count <= pkt_count + CNT_W'(1);
   end

   ////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         capture_en <= CTRL_EN_RST;
      else if (reg_wr_i && reg_addr_i == REG_CTRL)
         capture_en <= reg_wdata_i[CTRL_EN_BIT];
   end

   always_comb
   begin
      next_rdata = '0;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            REG_CTRL:
            begin
               next_rdata[CTRL_EN_BIT] = capture_en;
            end
            REG_STAT:
            begin
               next_rdata[STAT_VALID] = have_pkt;
               next_rdata[STAT_LAYOUT] = audio_metadata_bundle_o[SEL_BIT];
               next_rdata[STAT_CNT_LO +: CNT_W] = pkt_count;
            end
            default:
            begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_o <= '0;
      else
         reg_rdata_o <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////
   // Checking helpers: copy of the last accepted raw packet
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hdr_q  <= '0;
         body_q <= '0;
      end
      else if (cap)
      begin
         hdr_q  <= pkt_hdr_i;
         body_q <= pkt_body_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions
   property p_layout_sel;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o |->
         audio_metadata_bundle_o[SEL_BIT] == hdr_q[RAW_SEL_BIT];
   endproperty
   a_layout_sel: assert property (p_layout_sel)
      else $error("layout select does not follow packet");

   property p_counts;
      @(posedge mclk_i) disable iff (!rst_n)
      cap |=>
         audio_metadata_bundle_o[VIEWS_LO +: VIEWS_W] ==
            hdr_q[RAW_VIEWS_LO +: VIEWS_W] &&
         audio_metadata_bundle_o[STR_LO +: STR_W] ==
            hdr_q[RAW_STR_LO +: STR_W];
   endproperty
   a_counts: assert property (p_counts)
      else $error("view or stream count wrong");

   property p_only_capture;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o |-> $past(pkt_valid_i) && $past(pkt_ok_i);
   endproperty
   a_only_capture: assert property (p_only_capture)
      else $error("bundle updated without a good packet");

   property p_sp_cc;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[CC_LO +: CC_W] ==
            body_q[RAW_CC_LO +: CC_W] &&
         audio_metadata_bundle_o[GAPA_LO +: GAPA_W] == '0;
   endproperty
   a_sp_cc: assert property (p_sp_cc)
      else $error("spatial channel count field wrong");

   property p_sp_channel_alloc_standard;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[CHANNEL_ALLOC_STANDARD_LO +: CHANNEL_ALLOC_STANDARD_W] ==
            body_q[RAW_CHANNEL_ALLOC_STANDARD_LO +: CHANNEL_ALLOC_STANDARD_W] &&
         audio_metadata_bundle_o[GAPB_LO +: GAPB_W] == '0;
   endproperty
   a_sp_channel_alloc_standard: assert property (p_sp_channel_alloc_standard)
      else $error("allocation standard field wrong");

   property p_sp_spk;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SPK_LO +: SPK_W] ==
            body_q[RAW_SPK_LO +: SPK_W] &&
         audio_metadata_bundle_o[GAPC_LO +: GAPC_W] == '0;
   endproperty
   a_sp_spk: assert property (p_sp_spk)
      else $error("speaker allocation or upper zeros wrong");

   property p_ms_view;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_LEFT] == body_q[DSC_LEFT] &&
         audio_metadata_bundle_o[SUB_BASE+DSC_RIGHT] == body_q[DSC_RIGHT] &&
         audio_metadata_bundle_o[SUB_BASE+DSC_GA_LO +: DSC_GA_W] == '0;
   endproperty
   a_ms_view: assert property (p_ms_view)
      else $error("subpacket 0 view flags wrong");

   property p_ms_type;
      @(posedge mclk_i) disable iff (!rst_n)
      cap && !pkt_hdr_i[RAW_SEL_BIT] |=>
         audio_metadata_bundle_o[SUB_BASE+DSC_TYPE +: TYPE_W] ==
            body_q[DSC_TYPE +: TYPE_W];
   endproperty
   a_ms_type: assert property (p_ms_type)
      else $error("subpacket 0 supplementary type wrong");

   property p_ms_mixed;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_MIXED] == body_q[DSC_MIXED];
   endproperty
   a_ms_mixed: assert property (p_ms_mixed)
      else $error("subpacket 0 mixed flag wrong");

   property p_ms_svalid;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_SVALID] ==
            body_q[DSC_SVALID] &&
         audio_metadata_bundle_o[SUB_BASE+DSC_GB_LO +: DSC_GB_W] == '0;
   endproperty
   a_ms_svalid: assert property (p_ms_svalid)
      else $error("subpacket 0 supplementary flag wrong");

   property p_ms_lcv;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_LCV] == body_q[DSC_LCV];
   endproperty
   a_ms_lcv: assert property (p_ms_lcv)
      else $error("subpacket 0 language valid wrong");

   property p_ms_lang0;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_LANG +: LANG_W] ==
            body_q[DSC_LANG +: LANG_W];
   endproperty
   a_ms_lang0: assert property (p_ms_lang0)
      else $error("subpacket 0 language code wrong");

   property p_ms_repeat;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_W] == body_q[DSC_W] &&
         audio_metadata_bundle_o[SUB_BASE+2*DSC_W] == body_q[2*DSC_W] &&
         audio_metadata_bundle_o[SUB_BASE+3*DSC_W] == body_q[3*DSC_W] &&
         audio_metadata_bundle_o[SUB_BASE+DSC_W+DSC_GA_LO +: DSC_GA_W]
            == '0 &&
         audio_metadata_bundle_o[SUB_BASE+2*DSC_W+DSC_GB_LO +: DSC_GB_W]
            == '0;
   endproperty
   a_ms_repeat: assert property (p_ms_repeat)
      else $error("subpacket 1 to 3 descriptors misplaced");

   property p_ms_lang3;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[BUNDLE_W-1 -: LANG_W] ==
            body_q[BODY_W-1 -: LANG_W];
   endproperty
   a_ms_lang3: assert property (p_ms_lang3)
      else $error("subpacket 3 language code wrong");

   property p_ms_lang12;
      @(posedge mclk_i) disable iff (!rst_n)
      bundle_update_o && !audio_metadata_bundle_o[SEL_BIT] |->
         audio_metadata_bundle_o[SUB_BASE+DSC_W+DSC_LANG +: LANG_W] ==
            body_q[DSC_W+DSC_LANG +: LANG_W] &&
         audio_metadata_bundle_o[SUB_BASE+2*DSC_W+DSC_LANG +: LANG_W] ==
            body_q[2*DSC_W+DSC_LANG +: LANG_W];
   endproperty
   a_ms_lang12: assert property (p_ms_lang12)
      else $error("subpacket 1 and 2 language codes wrong");

   property p_refuse;
      @(posedge mclk_i) disable iff (!rst_n)
      pkt_valid_i && !pkt_ok_i |=> !bundle_update_o && $stable(audio_metadata_bundle_o);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("bad packet changed the bundle");

   property p_hold;
      @(posedge mclk_i) disable iff (!rst_n)
      !cap ##1 !cap |=> $stable(audio_metadata_bundle_o) && !bundle_update_o;
   endproperty
   a_hold: assert property (p_hold)
      else $error("bundle changed without a packet");

   property p_disable;
      @(posedge mclk_i) disable iff (!rst_n)
      reg_wr_i && reg_addr_i == REG_CTRL && !reg_wdata_i[CTRL_EN_BIT]
         ##1 (!reg_wr_i)[*2] |=> !bundle_update_o;
   endproperty
   a_disable: assert property (p_disable)
      else $error("capture happened while disabled");

   property p_rd_once;
      @(posedge mclk_i) disable iff (!rst_n)
      !reg_rd_i |=> reg_rdata_o == '0;
   endproperty
   a_rd_once: assert property (p_rd_once)
      else $error("read data outside its cycle");
endmodule : sink_audio_metadata_bundle

// *** bench/meta_user_model.sv ***
/*
 * Consumer-side model of the audio metadata bundle: latches the bundle
 * in each update pulse cycle and counts the pulses.
 * Assumes bundle and pulse are registered on mclk_i.
 */
`timescale 1ns/1ps
module meta_user_model
(
   input  wire logic                                 mclk_i,
   input  wire logic                                 arst_n_i,
   input  wire logic [meta_bundle_pkg::BUNDLE_W-1:0] bundle_i,
   input  wire logic                                 update_i,
   output logic      [meta_bundle_pkg::BUNDLE_W-1:0] held_o,
   output int                                        upd_count_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Sampling only in the pulse cycle shows up a pulse that leads its data
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         held_o      <= '0;
         upd_count_o <= 0;
      end
      else if (update_i)
      begin
         held_o      <= bundle_i;
         upd_count_o <= upd_count_o + 1;
      end
   end
endmodule : meta_user_model

// *** bench/sink_audio_metadata_bundle_tb_top.sv ***
/*
 * Self-checking bench for the metadata bundle: packets of both layouts,
 * refusals, back-to-back capture, register port and reset.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module sink_audio_metadata_bundle_tb_top;
   import meta_bundle_pkg::*;
   logic                mclk = 1'b0;
   logic                arst_n = 1'b0;
   logic                pkt_valid = 1'b0;
   logic                pkt_ok = 1'b0;
   logic [HDR_W-1:0]    pkt_hdr = '0;
   logic [BODY_W-1:0]   pkt_body = '0;
   logic [ADDR_W-1:0]   reg_addr = '0;
   logic [DATA_W-1:0]   reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [DATA_W-1:0]   reg_rdata;
   logic [BUNDLE_W-1:0] bundle;
   logic                bundle_upd;
   logic [BUNDLE_W-1:0] held;
   int                  upd_cnt;
   logic [BUNDLE_W-1:0] exp_b = '0;
   int                  cnt = 0;
   int                  fail_count = 0;
   int                  num_checks = 0;
   localparam logic [BODY_W-1:0] BA = {40'hA55A3C7E81, 40'h123456F9A7, 40'hC30F966C5C, 40'h7EDB243318};
   localparam logic [HDR_W-1:0]  HM = 16'hF62A;

   always #12.5 mclk = ~mclk;

   sink_audio_metadata_bundle i_dut (
      .mclk_i(mclk), .arst_n_i(arst_n), .pkt_valid_i(pkt_valid), .pkt_ok_i(pkt_ok),
      .pkt_hdr_i(pkt_hdr), .pkt_body_i(pkt_body), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .audio_metadata_bundle_o(bundle), .bundle_update_o(bundle_upd));

   meta_user_model i_user (
      .mclk_i(mclk), .arst_n_i(arst_n), .bundle_i(bundle), .update_i(bundle_upd),
      .held_o(held), .upd_count_o(upd_cnt));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [BUNDLE_W-1:0] exp_of(input logic [HDR_W-1:0] h, input logic [BODY_W-1:0] d);
      logic [BUNDLE_W-1:0] b;
      b = '0;
      b[0] = h[0];
      b[2:1] = h[9:8];
      b[4:3] = h[11:10];
      if (h[0])
      begin
         b[9:5] = d[4:0];
         b[16:13] = d[19:16];
         b[28:21] = d[31:24];
      end
      else
      begin
         // Keeps left, right, type, mixed, valid, lang valid, language
         for (int k = 0; k < 4; k++)
            b[5+40*k +: 40] = d[40*k +: 40] & 40'hFFFFFF9F03;
      end
      return b;
   endfunction : exp_of

   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         $display("MISMATCH t=%0t %s", $time, msg);
         fail_count++;
      end
   endtask : chk

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string msg);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata === e, msg);
      @(posedge mclk);
      #1 chk(reg_rdata === '0, "read data not cleared");
   endtask : reg_read

   // One packet; take says whether the block should capture it
   task automatic send(input logic [HDR_W-1:0] h, input logic [BODY_W-1:0] d, input logic ok, input logic take);
      @(posedge mclk);
      pkt_valid <= 1'b1;
      pkt_ok    <= ok;
      pkt_hdr   <= h;
      pkt_body  <= d;
      @(posedge mclk);
      pkt_valid <= 1'b0;
      if (take)
      begin
         exp_b = exp_of(h, d);
         cnt++;
      end
      #1 chk(bundle_upd === take && bundle === exp_b, "bundle after packet");
      @(posedge mclk);
      #1 chk(bundle_upd === 1'b0 && bundle === exp_b, "bundle not held");
      chk(held === exp_b, "consumer copy differs");
   endtask : send

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      #1 chk(bundle === '0 && bundle_upd === 1'b0, "bundle not zero after reset");
      reg_read(REG_CTRL, 32'h00000001, "control reset value");
      reg_read(REG_STAT, 32'h00000000, "status reset value");
      $display("test reset done");
   endtask : t_reset

   task automatic t_spatial();
      for (int i = 0; i < 4; i++)
         send({4'hA, i[1:0], 2'(3 - i), 7'h55, 1'b1}, i[0] ? '1 : BA, 1'b1, 1'b1);
      chk(bundle[164:29] === '0, "spatial upper bits not zero");
      $display("test spatial done");
   endtask : t_spatial

   task automatic t_multi();
      send(HM, BA, 1'b1, 1'b1);
      chk(bundle[164:141] === BA[159:136], "sub 3 language");
      chk(bundle[45] === BA[40] && bundle[85] === BA[80], "sub 1 and 2 left view");
      send(HM, ~BA, 1'b1, 1'b1);
      $display("test multi done");
   endtask : t_multi

   task automatic t_refuse();
      send(16'h0001, '1, 1'b0, 1'b0);
      reg_write(REG_CTRL, 32'h00000000);
      reg_read(REG_CTRL, 32'h00000000, "control write");
      send(16'h0001, '1, 1'b1, 1'b0);
      reg_write(4'hC, 32'h00000001);
      reg_read(REG_CTRL, 32'h00000000, "unmapped write leaked");
      reg_write(REG_CTRL, 32'h00000001);
      reg_read(4'h8, 32'h00000000, "unmapped read");
      send(16'h0001, '1, 1'b1, 1'b1);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_b2b();
      logic [BUNDLE_W-1:0] e1;
      e1 = exp_of(16'h0501, BA);
      @(posedge mclk);
      pkt_valid <= 1'b1;
      pkt_ok    <= 1'b1;
      pkt_hdr   <= 16'h0501;
      pkt_body  <= BA;
      @(posedge mclk);
      pkt_hdr   <= HM;
      pkt_body  <= BA;
      #1 chk(bundle_upd === 1'b1 && bundle === e1, "first of pair");
      @(posedge mclk);
      pkt_valid <= 1'b0;
      exp_b = exp_of(HM, BA);
      cnt += 2;
      #1 chk(bundle_upd === 1'b1 && bundle === exp_b, "second of pair");
      @(posedge mclk);
      #1 chk(bundle_upd === 1'b0 && bundle === exp_b, "pair not held");
      chk(upd_cnt === cnt, "update pulse count");
      reg_read(REG_STAT, {16'h0, 8'(cnt), 6'h0, exp_b[0], 1'b1}, "status after traffic");
      $display("test back to back done");
   endtask : t_b2b

   task automatic t_midreset();
      @(posedge mclk);
      arst_n <= 1'b0;
      @(posedge mclk);
      #1 chk(bundle === '0 && bundle_upd === 1'b0, "bundle not cleared in reset");
      @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk(bundle === '0, "bundle not zero after second reset");
      reg_read(REG_STAT, 32'h00000000, "status after second reset");
      $display("test mid reset done");
   endtask : t_midreset

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_spatial();
      t_multi();
      t_refuse();
      t_b2b();
      t_midreset();
      results();
   end

   // About 70 cycles of traffic; far more is a hang
   initial
   begin
      #(2000 * 25);
      fail_count++;
      results();
   end
endmodule : sink_audio_metadata_bundle_tb_top
